//--- rtl/ppm_port_mux.sv
// Purpose: Port pin configuration registers and alternate function multiplexing
// Assumes: Pins are asynchronous; peripherals share the core clock
// Notes: Pin index is port * 8 + bit; port slot 3 has no pins and no registers
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`include "ppm_map.svh"

// What this block does
// [RULE1] Each pin bit is configured on its own as input, output or bidirectional
// [RULE2] Pins without Schmitt input take TTL or CMOS threshold from threshold bit
// [RULE3] Ports 4, 5, 7, 8, 9 use Schmitt input except port 7 pins in analog mode, threshold bit ignored
// [RULE4] Outputs are push-pull or open-drain; open-drain never drives high
// [RULE5] Reset leaves all bits bidirectional; pull-up on ports 0,1,4,5,7,8,9
// [RULE6] At most one alternate function owns or listens to a pin
// [RULE7] Alternate inputs reach their peripheral when it is enabled and the pin is neither analog nor alternate-driven
// [RULE8] Converter inputs connect only on explicit configuration, never by enable
// [RULE9] Alternate outputs drive the pin only when software selects alternate mode
// [RULE10] Code threshold 1, mode 01 gives a Schmitt input, e.g. serial receive
// [RULE11] Code threshold 0, mode 11 gives push-pull alternate output, e.g. transmit
// [RULE12] Code 111 on converter pins connects the analog input
// [RULE13] Code 011 on memory pins gives bidirectional bus under memory control
// [RULE14] Port 0 carries address/data 0-7, port 1 address 8-15 in order
// [RULE15] Port 5 pins carry the listed timer, serial and clock functions
// [RULE16] A configuration write reaches the pin one cycle later without glitches
// [RULE17] Software writes all three configuration bits before enabling the peripheral
module ppm_port_mux (
  input wire logic i_ref_clk, // Core clock, 100 MHz
  input wire logic i_reset_n, // Async reset, active low
  input wire logic i_clk_en, // Freezes all state when low
  input wire logic [`PPM_ADDR_W-1:0] i_addr, // Register address {port, select}
  input wire logic [7:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [7:0] o_rdata, // Read data, cycle after the strobe
  input wire logic [`PPM_NUM_PINS-1:0] i_pin_in, // Pad input levels
  output logic [`PPM_NUM_PINS-1:0] o_pin_out, // Pad output values
  output logic [`PPM_NUM_PINS-1:0] o_pin_oe, // Pad output enables
  output logic [`PPM_NUM_PINS-1:0] o_pin_weak_pullup, // Weak pull-up enables
  output logic [`PPM_NUM_PINS-1:0] o_pin_schmitt, // Schmitt input selected
  output logic [`PPM_NUM_PINS-1:0] o_pin_cmos, // CMOS threshold selected
  output logic [7:0] o_analog_input_sel, // Port 7 pins handed to converter
  input wire logic i_mem_en, // External memory interface active
  input wire logic [7:0] i_mem_addr_data_out, // Multiplexed address/data out
  input wire logic i_mem_addr_data_oe, // Memory drives address/data
  input wire logic [7:0] i_mem_high_addr, // Address bits 8 to 15
  output logic [7:0] o_mem_addr_data_in, // Data read back from port 0
  input wire logic i_internal_clock_out, // Clock for pin 4.2
  input wire logic i_standard_timer_out, // Timer for pin 4.3
  input wire logic i_watchdog_out, // Watchdog for pin 4.4
  input wire logic i_timer0_output_a, // Timer 0 A for pin 4.7
  input wire logic i_timer0_output_b, // Timer 0 B for pin 4.6
  input wire logic i_timer1_output_a, // Timer 1 A for pin 5.4
  input wire logic i_timer1_output_b, // Timer 1 B for pin 5.5
  input wire logic i_timer3_output_a, // Timer 3 A for pin 5.6
  input wire logic i_timer3_output_b, // Timer 3 B for pin 5.7
  input wire logic i_serial0_request_to_send, // Serial 0 RTS for pin 5.5
  input wire logic i_serial1_request_to_send, // Serial 1 RTS for pin 5.7
  input wire logic i_serial0_tx_data, // Serial 0 transmit for pin 9.4
  input wire logic [2:0] i_ext_irq_en, // Enables of irq 0, 4, 5
  input wire logic i_spi_en, // Serial peripheral enabled
  input wire logic i_serial0_en, // Serial 0 enabled
  input wire logic i_serial1_en, // Serial 1 enabled
  input wire logic i_ext_clock_en, // External clock input in use
  output logic o_ext_irq0, // From pin 4.4
  output logic o_ext_irq4, // From pin 4.5
  output logic o_ext_irq5, // From pin 4.6
  output logic o_serial_periph_data_in, // From pin 5.1
  output logic o_serial0_carrier_detect, // From pin 5.4
  output logic o_serial1_carrier_detect, // From pin 5.6
  output logic o_external_alt_clock_in, // From pin 5.7
  output logic o_serial0_rx_data // From pin 9.5
);

  // Peripheral input: pin level when allowed, idle level otherwise
  function automatic logic route_in(input logic en, input logic ok, input logic lvl);
    return (en & ok) ? lvl : `PPM_AF_IN_IDLE;
  endfunction

  // Port slot present in the package
  function automatic logic port_fitted(input logic [3:0] port);
    logic [9:0] fitted;
    fitted = `PPM_PORT_EXISTS;
    return (port < 4'ha) ? fitted[port] : 1'b0;
  endfunction

  logic [`PPM_NUM_PINS-1:0] data_ff;
  logic [`PPM_NUM_PINS-1:0] cfg0_ff;
  logic [`PPM_NUM_PINS-1:0] cfg1_ff;
  logic [`PPM_NUM_PINS-1:0] cfg2_ff;
  logic [`PPM_NUM_PINS-1:0] alt_ff;
  logic [`PPM_NUM_PINS-1:0] nxt_data;
  logic [`PPM_NUM_PINS-1:0] nxt_cfg0;
  logic [`PPM_NUM_PINS-1:0] nxt_cfg1;
  logic [`PPM_NUM_PINS-1:0] nxt_cfg2;
  logic [`PPM_NUM_PINS-1:0] nxt_alt;
  logic [`PPM_NUM_PINS-1:0] sync1_ff;
  logic [`PPM_NUM_PINS-1:0] sync2_ff;
  logic [`PPM_NUM_PINS-1:0] af_out;
  logic [`PPM_NUM_PINS-1:0] af_oe;
  logic [`PPM_NUM_PINS-1:0] af_has;
  logic [`PPM_NUM_PINS-1:0] in_ok;
  logic [`PPM_NUM_PINS-1:0] is_af;
  logic [`PPM_NUM_PINS-1:0] is_analog;
  ppm_pkg::ppm_mode_t pin_mode [`PPM_NUM_PINS];
  logic [7:0] rd_byte;
  logic [7:0] mem_in_ff;

  // Bus decode
  wire [3:0] bus_port = i_addr[6:3];
  wire [2:0] bus_sel = i_addr[2:0];
  wire port_ok = port_fitted(bus_port);
  wire wr_ok = i_wr & port_ok;
  wire [6:0] base = {bus_port[3:0], 3'h0};

  // Register write: only the addressed byte changes
  always_comb begin
    nxt_data = data_ff;
    nxt_cfg0 = cfg0_ff;
    nxt_cfg1 = cfg1_ff;
    nxt_cfg2 = cfg2_ff;
    nxt_alt = alt_ff;
    if (wr_ok) begin
      case (bus_sel)
        `PPM_SEL_DATA: nxt_data[base +: 8] = i_wdata;
        `PPM_SEL_CFG0: nxt_cfg0[base +: 8] = i_wdata; // RULE1
        `PPM_SEL_CFG1: nxt_cfg1[base +: 8] = i_wdata; // RULE1
        `PPM_SEL_CFG2: nxt_cfg2[base +: 8] = i_wdata; // RULE1
        `PPM_SEL_ALT: nxt_alt[base +: 8] = i_wdata;
        default: nxt_data = data_ff; // Pin register is read only
      endcase
    end
  end

  // Read mux; unfitted ports and unused selects read zero
  always_comb begin
    rd_byte = 8'h00;
    if (port_ok) begin
      case (bus_sel)
        `PPM_SEL_DATA: rd_byte = data_ff[base +: 8];
        `PPM_SEL_CFG0: rd_byte = cfg0_ff[base +: 8];
        `PPM_SEL_CFG1: rd_byte = cfg1_ff[base +: 8];
        `PPM_SEL_CFG2: rd_byte = cfg2_ff[base +: 8];
        `PPM_SEL_PIN: rd_byte = sync2_ff[base +: 8];
        `PPM_SEL_ALT: rd_byte = alt_ff[base +: 8];
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Configuration registers; reset value 000 makes every bit bidirectional
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      data_ff <= {`PPM_NUM_PORTS{`PPM_DATA_RST}};
      cfg0_ff <= {`PPM_NUM_PORTS{`PPM_CFG_RST}}; // RULE5
      cfg1_ff <= {`PPM_NUM_PORTS{`PPM_CFG_RST}}; // RULE5
      cfg2_ff <= {`PPM_NUM_PORTS{`PPM_CFG_RST}}; // RULE5
      alt_ff <= {`PPM_NUM_PORTS{`PPM_ALT_RST}};
    end else if (i_clk_en) begin
      data_ff <= nxt_data;
      cfg0_ff <= nxt_cfg0;
      cfg1_ff <= nxt_cfg1;
      cfg2_ff <= nxt_cfg2;
      alt_ff <= nxt_alt;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (i_clk_en) begin
      o_rdata <= i_rd ? rd_byte : 8'h00;
    end
  end

  // Two-flop synchroniser on every pad input
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else if (i_clk_en) begin
      sync1_ff <= i_pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Alternate output sources; the select bit picks one of two
  always_comb begin
    af_out = '0;
    af_oe = '0;
    af_has = '0;
    // Memory bus: port 0 turns around, port 1 drives whenever i_mem_en is high
    af_out[7:0] = i_mem_addr_data_out; // RULE14
    af_oe[7:0] = {8{i_mem_en & i_mem_addr_data_oe}}; // RULE13
    af_has[7:0] = 8'hff;
    af_out[15:8] = i_mem_high_addr; // RULE14
    af_oe[15:8] = {8{i_mem_en}};
    af_has[15:8] = 8'hff;
    // Port 4 outputs
    af_out[`PPM_PIN_P4_2] = i_internal_clock_out;
    af_out[`PPM_PIN_P4_3] = i_standard_timer_out;
    af_out[`PPM_PIN_P4_4] = i_watchdog_out;
    af_out[`PPM_PIN_P4_6] = i_timer0_output_b;
    af_out[`PPM_PIN_P4_7] = i_timer0_output_a;
    af_has[`PPM_PIN_P4_2] = 1'b1;
    af_has[`PPM_PIN_P4_3] = 1'b1;
    af_has[`PPM_PIN_P4_4] = 1'b1;
    af_has[`PPM_PIN_P4_6] = 1'b1;
    af_has[`PPM_PIN_P4_7] = 1'b1;
    // Port 5 outputs, each two-way choice gives one source
    af_out[`PPM_PIN_P5_4] = i_timer1_output_a; // RULE15
    af_out[`PPM_PIN_P5_5] = alt_ff[`PPM_PIN_P5_5] ? i_timer1_output_b : i_serial0_request_to_send; // RULE6 RULE15
    af_out[`PPM_PIN_P5_6] = i_timer3_output_a; // RULE15
    af_out[`PPM_PIN_P5_7] = alt_ff[`PPM_PIN_P5_7] ? i_timer3_output_b : i_serial1_request_to_send; // RULE6 RULE15
    af_has[`PPM_PIN_P5_4] = 1'b1;
    af_has[`PPM_PIN_P5_5] = 1'b1;
    af_has[`PPM_PIN_P5_6] = 1'b1;
    af_has[`PPM_PIN_P5_7] = 1'b1;
    // Port 9 serial transmit
    af_out[`PPM_PIN_P9_4] = i_serial0_tx_data; // RULE11
    af_has[`PPM_PIN_P9_4] = 1'b1;
    // Ordinary alternate outputs drive whenever selected
    af_oe[`PPM_NUM_PINS-1:16] = af_has[`PPM_NUM_PINS-1:16];
  end

  // One cell per pin; capabilities follow the port masks
  for (genvar g = 0; g < `PPM_NUM_PINS; g++) begin : g_pin
    localparam logic [9:0] WPU_MASK = `PPM_PORT_WPU;
    localparam logic [9:0] SCH_MASK = `PPM_PORT_SCHMITT;
    ppm_pin_cell #(
      .P_WPU(WPU_MASK[g / 8]),
      .P_SCHMITT(SCH_MASK[g / 8]),
      .P_ANALOG((g / 8) == `PPM_ANALOG_PORT)
    ) u_cell (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_clk_en(i_clk_en),
      .i_cfg_thr(cfg2_ff[g]),
      .i_cfg_m1(cfg1_ff[g]),
      .i_cfg_m0(cfg0_ff[g]),
      .i_latch(data_ff[g]),
      .i_af_out(af_out[g]),
      .i_af_oe(af_oe[g]),
      .i_af_has(af_has[g]),
      .o_pin_out(o_pin_out[g]),
      .o_pin_oe(o_pin_oe[g]),
      .o_pullup(o_pin_weak_pullup[g]),
      .o_schmitt(o_pin_schmitt[g]),
      .o_cmos(o_pin_cmos[g]),
      .o_analog(),
      .o_mode(pin_mode[g])
    );
    // Alternate-driven and analog pins feed no alternate input
    assign is_af[g] = (pin_mode[g] == ppm_pkg::PPM_MODE_AF);
    assign is_analog[g] = (pin_mode[g] == ppm_pkg::PPM_MODE_ANALOG);
    assign in_ok[g] = ~is_analog[g] & ~(is_af[g] & af_has[g]); // RULE6
  end

  // Converter select follows the pin code, not the converter enable
  assign o_analog_input_sel = is_analog[63:56]; // RULE8

  // Alternate inputs routed implicitly by peripheral enable
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ext_irq0 <= `PPM_AF_IN_IDLE;
      o_ext_irq4 <= `PPM_AF_IN_IDLE;
      o_ext_irq5 <= `PPM_AF_IN_IDLE;
      o_serial_periph_data_in <= `PPM_AF_IN_IDLE;
      o_serial0_carrier_detect <= `PPM_AF_IN_IDLE;
      o_serial1_carrier_detect <= `PPM_AF_IN_IDLE;
      o_external_alt_clock_in <= `PPM_AF_IN_IDLE;
      o_serial0_rx_data <= `PPM_AF_IN_IDLE;
    end else if (i_clk_en) begin
      o_ext_irq0 <= route_in(i_ext_irq_en[0], in_ok[`PPM_PIN_P4_4], sync2_ff[`PPM_PIN_P4_4]); // RULE7
      o_ext_irq4 <= route_in(i_ext_irq_en[1], in_ok[`PPM_PIN_P4_5], sync2_ff[`PPM_PIN_P4_5]); // RULE7
      o_ext_irq5 <= route_in(i_ext_irq_en[2], in_ok[`PPM_PIN_P4_6], sync2_ff[`PPM_PIN_P4_6]); // RULE7
      o_serial_periph_data_in <= route_in(i_spi_en, in_ok[`PPM_PIN_P5_1], sync2_ff[`PPM_PIN_P5_1]); // RULE15
      o_serial0_carrier_detect <= route_in(i_serial0_en, in_ok[`PPM_PIN_P5_4], sync2_ff[`PPM_PIN_P5_4]); // RULE15
      o_serial1_carrier_detect <= route_in(i_serial1_en, in_ok[`PPM_PIN_P5_6], sync2_ff[`PPM_PIN_P5_6]); // RULE15
      o_external_alt_clock_in <= route_in(i_ext_clock_en, in_ok[`PPM_PIN_P5_7], sync2_ff[`PPM_PIN_P5_7]); // RULE15
      o_serial0_rx_data <= route_in(i_serial0_en, in_ok[`PPM_PIN_P9_5], sync2_ff[`PPM_PIN_P9_5]); // RULE7 RULE10
    end
  end

  // Memory read data only from port 0 bits set to the alternate code
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mem_in_ff <= 8'h00;
    end else if (i_clk_en) begin
      mem_in_ff <= sync2_ff[7:0] & is_af[7:0]; // RULE13 RULE14
    end
  end
  assign o_mem_addr_data_in = mem_in_ff;

endmodule

//--- rtl/ppm_map.svh
// Purpose: Offsets, field positions and reset values of the port pin mux
// Assumes: Address is {port[3:0], select[2:0]}, one byte per register
// Notes: Definitions only, guarded against double inclusion
`ifndef PPM_MAP_SVH
`define PPM_MAP_SVH

// Geometry: ten port slots of eight bits, slot 3 is not fitted
`define PPM_NUM_PORTS 10
`define PPM_NUM_PINS 80
`define PPM_ADDR_W 7

// Register selects inside one port
`define PPM_SEL_DATA 3'h0
`define PPM_SEL_CFG0 3'h1
`define PPM_SEL_CFG1 3'h2
`define PPM_SEL_CFG2 3'h3
`define PPM_SEL_PIN 3'h4
`define PPM_SEL_ALT 3'h5

// Capability masks, bit n is port n
`define PPM_PORT_EXISTS 10'h3f7
`define PPM_PORT_WPU 10'h3b3
`define PPM_PORT_SCHMITT 10'h3b0
`define PPM_ANALOG_PORT 4'h7
`define PPM_MEM_AD_PORT 4'h0
`define PPM_MEM_HI_PORT 4'h1

// Reset values
`define PPM_DATA_RST 8'hff
`define PPM_CFG_RST 8'h00
`define PPM_ALT_RST 8'h00
`define PPM_AF_IN_IDLE 1'b1

// Alternate function pins, index = port * 8 + bit
`define PPM_PIN_P4_2 7'h22
`define PPM_PIN_P4_3 7'h23
`define PPM_PIN_P4_4 7'h24
`define PPM_PIN_P4_5 7'h25
`define PPM_PIN_P4_6 7'h26
`define PPM_PIN_P4_7 7'h27
`define PPM_PIN_P5_1 7'h29
`define PPM_PIN_P5_4 7'h2c
`define PPM_PIN_P5_5 7'h2d
`define PPM_PIN_P5_6 7'h2e
`define PPM_PIN_P5_7 7'h2f
`define PPM_PIN_P9_4 7'h4c
`define PPM_PIN_P9_5 7'h4d

`endif

//--- rtl/ppm_pkg.sv
// Purpose: Types shared by the port pin mux files
// Assumes: Nothing is imported, users write ppm_pkg::name
// Notes: Pin mode is one-hot so each mode test is a single bit
package ppm_pkg;

  // Decoded operating mode of one pin
  typedef enum logic [4:0] {
    PPM_MODE_BIDIR = 5'h01,
    PPM_MODE_INPUT = 5'h02,
    PPM_MODE_OUTPUT = 5'h04,
    PPM_MODE_AF = 5'h08,
    PPM_MODE_ANALOG = 5'h10
  } ppm_mode_t;

endpackage

//--- rtl/ppm_pin_cell.sv
// Purpose: One pin: decodes its configuration and drives the pad controls
// Assumes: Capabilities of the pin are fixed by parameters
// Notes: All pad controls come from flops so unchanged pins never glitch
`timescale 1ns/1ns
module ppm_pin_cell #(
  parameter bit P_WPU = 1'b0,
  parameter bit P_SCHMITT = 1'b0,
  parameter bit P_ANALOG = 1'b0
) (
  input wire logic i_ref_clk, // Core clock
  input wire logic i_reset_n, // Async reset, active low
  input wire logic i_clk_en, // Freezes state when low
  input wire logic i_cfg_thr, // Threshold select bit
  input wire logic i_cfg_m1, // Mode bit 1
  input wire logic i_cfg_m0, // Mode bit 0
  input wire logic i_latch, // General purpose output latch
  input wire logic i_af_out, // Alternate function output value
  input wire logic i_af_oe, // Alternate function wants to drive
  input wire logic i_af_has, // Pin owns an alternate output
  output logic o_pin_out, // Pad output value
  output logic o_pin_oe, // Pad output enable
  output logic o_pullup, // Weak pull-up enable
  output logic o_schmitt, // Schmitt input in use
  output logic o_cmos, // CMOS threshold in use
  output logic o_analog, // Pad handed to the converter
  output ppm_pkg::ppm_mode_t o_mode // Decoded mode, combinational
);

  // Three configuration bits to a mode
  function automatic ppm_pkg::ppm_mode_t decode_mode(input logic thr, input logic m1, input logic m0);
    ppm_pkg::ppm_mode_t m;
    m = ppm_pkg::PPM_MODE_BIDIR;
    case ({m1, m0})
      2'h0: m = ppm_pkg::PPM_MODE_BIDIR;
      2'h1: m = ppm_pkg::PPM_MODE_INPUT; // RULE10
      2'h2: m = ppm_pkg::PPM_MODE_OUTPUT;
      2'h3: m = (thr & P_ANALOG) ? ppm_pkg::PPM_MODE_ANALOG : ppm_pkg::PPM_MODE_AF; // RULE11 RULE12 RULE13
      default: m = ppm_pkg::PPM_MODE_BIDIR;
    endcase
    return m;
  endfunction

  wire mode_bidir;
  wire mode_out;
  wire mode_af;
  wire mode_analog;
  wire od_sel;
  wire out_val;
  wire drive_en;
  wire nxt_pin_out;
  wire nxt_pin_oe;

  // Mode decode and pad control
  assign o_mode = decode_mode(i_cfg_thr, i_cfg_m1, i_cfg_m0); // RULE1
  assign mode_bidir = (o_mode == ppm_pkg::PPM_MODE_BIDIR);
  assign mode_out = (o_mode == ppm_pkg::PPM_MODE_OUTPUT);
  assign mode_af = (o_mode == ppm_pkg::PPM_MODE_AF);
  assign mode_analog = (o_mode == ppm_pkg::PPM_MODE_ANALOG);
  // Bidirectional lines only pull low; outside drivers own the high level
  assign od_sel = mode_bidir | (i_cfg_thr & (mode_out | mode_af)); // RULE4
  assign out_val = mode_af ? i_af_out : i_latch; // RULE9
  assign drive_en = mode_bidir | mode_out | (mode_af & i_af_has & i_af_oe); // RULE9
  assign nxt_pin_oe = drive_en & (~od_sel | ~out_val); // RULE4
  assign nxt_pin_out = od_sel ? 1'b0 : out_val; // RULE4

  // Registered pad controls
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pin_out <= 1'b0;
      o_pin_oe <= 1'b0;
      o_pullup <= P_WPU; // RULE5
      o_schmitt <= P_SCHMITT;
      o_cmos <= 1'b0;
      o_analog <= 1'b0;
    end else if (i_clk_en) begin
      o_pin_out <= nxt_pin_out; // RULE16
      o_pin_oe <= nxt_pin_oe; // RULE16
      o_pullup <= P_WPU & mode_bidir; // RULE5
      o_schmitt <= P_SCHMITT & ~mode_analog; // RULE3
      o_cmos <= ~P_SCHMITT & i_cfg_thr & ~mode_analog; // RULE2 RULE3
      o_analog <= mode_analog; // RULE8 RULE12
    end
  end

endmodule

//--- tb/ppm_pad_model.sv
// Purpose: Pads and outside drivers around the port pin mux
// Assumes: An outside driver beats the weak pull-up of a pin
// Notes: Undriven pins without pull-up show the inverse of the design value
`timescale 1ns/1ns
module ppm_pad_model (
  input wire logic i_ref_clk, // Core clock
  input wire logic [79:0] i_out, // Design pad values
  input wire logic [79:0] i_oe, // Design pad enables
  input wire logic [79:0] i_pullup, // Design weak pull-ups
  input wire logic [79:0] i_ext_en, // Outside driver active
  input wire logic [79:0] i_ext_val, // Outside driver value
  output logic [79:0] o_level // Resolved pad levels
);
  // Design driver wins, then outside driver, then pull-up or the inverse of the design value
  assign o_level = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val) |
                   (~i_oe & ~i_ext_en & (i_pullup | ~i_out));
endmodule

//--- tb/ppm_port_mux_checker.sv
// Purpose: Concurrent checks on the port pin mux top ports
// Assumes: Port 1 configuration is shadowed by watching bus writes
// Notes: Pad checks that follow configuration or inputs use $past, as pads lag the registers a cycle
`timescale 1ns/1ns
`include "ppm_map.svh"
module ppm_port_mux_checker (
  input wire logic i_ref_clk, // Core clock
  input wire logic i_reset_n, // Async reset, active low
  input wire logic i_clk_en, // Run enable
  input wire logic [6:0] i_addr, // Register address
  input wire logic [7:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic [79:0] i_pin_in, // Pad levels
  input wire logic [79:0] o_pin_out, // Pad values
  input wire logic [79:0] o_pin_oe, // Pad enables
  input wire logic [79:0] o_pin_weak_pullup, // Pull-ups
  input wire logic [79:0] o_pin_schmitt, // Schmitt inputs
  input wire logic [7:0] o_analog_input_sel, // Converter pins
  input wire logic i_mem_en, // Memory interface on
  input wire logic [7:0] i_mem_high_addr, // High address
  input wire logic i_serial0_en, // Serial 0 on
  input wire logic o_serial0_rx_data // Serial 0 receive
);
  logic [7:0] lat_ff;
  logic [7:0] m0_ff;
  logic [7:0] m1_ff;
  logic [7:0] thr_ff;

  // Shadow of the port 1 registers
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lat_ff <= `PPM_DATA_RST;
      m0_ff <= `PPM_CFG_RST;
      m1_ff <= `PPM_CFG_RST;
      thr_ff <= `PPM_CFG_RST;
    end else if (i_clk_en && i_wr && i_addr[6:3] == 4'h1) begin
      if (i_addr[2:0] == `PPM_SEL_DATA) lat_ff <= i_wdata;
      if (i_addr[2:0] == `PPM_SEL_CFG0) m0_ff <= i_wdata;
      if (i_addr[2:0] == `PPM_SEL_CFG1) m1_ff <= i_wdata;
      if (i_addr[2:0] == `PPM_SEL_CFG2) thr_ff <= i_wdata;
    end
  end

  // Bit classes by code
  wire [7:0] pp_out = ~thr_ff & m1_ff & ~m0_ff;
  wire [7:0] inp = ~m1_ff & m0_ff;
  wire [7:0] alt_pp = ~thr_ff & m1_ff & m0_ff;
  wire [7:0] no_high = (thr_ff & m1_ff) | ~(m1_ff | m0_ff);

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_rx_steady;
    (i_clk_en && i_serial0_en && $stable(i_pin_in[77])) [*5];
  endsequence

  chk_reset_pads: assert property ($rose(i_reset_n) |-> o_pin_oe == 80'h0 &&
    o_pin_weak_pullup == 80'hffffff00ffff0000ffff) else $error("pads wrong after reset");
  chk_schmitt_fixed: assert property ({o_pin_schmitt[79:64], o_pin_schmitt[47:32]} == 32'hffffffff)
    else $error("schmitt lost");
  chk_ttl_ports: assert property ({o_pin_schmitt[55:48], o_pin_schmitt[23:16]} == 16'h0000)
    else $error("schmitt on ttl port");
  chk_od_no_high: assert property ($past(i_clk_en) |-> (o_pin_oe[15:8] & o_pin_out[15:8] & $past(no_high)) == 8'h00)
    else $error("high in low-only mode");
  chk_gp_output: assert property ($past(i_clk_en) |-> (o_pin_oe[15:8] & $past(pp_out | inp)) == $past(pp_out) &&
    ((o_pin_out[15:8] ^ $past(lat_ff)) & $past(pp_out)) == 8'h00) else $error("general output wrong");
  chk_high_addr: assert property ($past(i_clk_en && i_mem_en) |-> (o_pin_oe[15:8] & $past(alt_pp)) == $past(alt_pp) &&
    ((o_pin_out[15:8] ^ $past(i_mem_high_addr)) & $past(alt_pp)) == 8'h00) else $error("high address wrong");
  chk_analog_write: assert property (!$past(i_wr) |-> $stable(o_analog_input_sel))
    else $error("analog moved without write");
  chk_rx_follow: assert property (s_rx_steady |-> o_serial0_rx_data == i_pin_in[77])
    else $error("rx not routed");
  chk_rx_idle: assert property ((!i_serial0_en) [*3] |-> o_serial0_rx_data)
    else $error("rx routed while off");
endmodule

bind ppm_port_mux ppm_port_mux_checker i_chk (.*);

//--- tb/ppm_port_mux_test.sv
// Purpose: Register-driven test of the port pin mux
// Assumes: Pad model resolves pins; clock enable stays high
// Notes: Outside drivers act only where a test asks
`timescale 1ns/1ns
module ppm_port_mux_test;
  logic i_ref_clk, i_reset_n, i_clk_en, i_wr, i_rd, i_mem_en, i_mem_addr_data_oe;
  logic [6:0] i_addr;
  logic [7:0] i_wdata, i_mem_addr_data_out, i_mem_high_addr, o_rdata, o_analog_input_sel, o_mem_addr_data_in;
  logic [79:0] o_pin_out, o_pin_oe, o_pin_weak_pullup, o_pin_schmitt, o_pin_cmos, ext_en, ext_val;
  logic o_ext_irq0, o_ext_irq4, o_ext_irq5, o_serial_periph_data_in, o_serial0_carrier_detect;
  logic o_serial1_carrier_detect, o_external_alt_clock_in, o_serial0_rx_data;
  logic [11:0] pf;
  logic [6:0] en;
  int n_fail = 0;
  int comparisons = 0;
  wire [79:0] i_pin_in;
  // Peripheral outputs and enables from two vectors
  wire i_internal_clock_out = pf[0], i_standard_timer_out = pf[1], i_watchdog_out = pf[2];
  wire i_timer0_output_a = pf[3], i_timer0_output_b = pf[4], i_timer1_output_a = pf[5], i_timer1_output_b = pf[6];
  wire i_timer3_output_a = pf[7], i_timer3_output_b = pf[8], i_serial0_request_to_send = pf[9];
  wire i_serial1_request_to_send = pf[10], i_serial0_tx_data = pf[11];
  wire i_spi_en = en[0], i_serial0_en = en[1], i_serial1_en = en[2], i_ext_clock_en = en[3];
  wire [2:0] i_ext_irq_en = en[6:4];
  wire [7:0] periph = {o_serial0_rx_data, o_external_alt_clock_in, o_serial1_carrier_detect,
    o_serial0_carrier_detect, o_serial_periph_data_in, o_ext_irq5, o_ext_irq4, o_ext_irq0};

  ppm_port_mux i_dut (.*);
  ppm_pad_model i_pads (.i_ref_clk(i_ref_clk), .i_out(o_pin_out), .i_oe(o_pin_oe), .i_pullup(o_pin_weak_pullup),
    .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(i_pin_in));

  task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    i_wr <= 1'b0;
    @(posedge i_ref_clk);
    #1 check("rdata", o_rdata, e);
  endtask
  task automatic idle(input int n);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic close_out();
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // Hang guard, about 25 times the test length
  initial begin
    #20000;
    n_fail++;
    close_out();
  end

  initial begin
    {i_reset_n, i_wr, i_rd, i_addr, i_wdata, i_mem_en, i_mem_addr_data_oe} = '0;
    {i_mem_addr_data_out, i_mem_high_addr, pf, en, ext_en, ext_val} = '0;
    i_clk_en = 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    idle(1);
    check("pullup", o_pin_weak_pullup, 80'hffffff00ffff0000ffff);
    check("oe", o_pin_oe, 80'h0);
    rd(7'h08, 8'hff);
    // Port 1: bit 0 input, rest push-pull
    wr(7'h08, 8'h5a);
    wr(7'h0a, 8'hfe);
    wr(7'h09, 8'h01);
    idle(1);
    check("p1 oe", o_pin_oe[15:8], 8'hfe);
    check("p1 out", o_pin_out[15:9], 7'h2d);
    rd(7'h0a, 8'hfe);
    wr(7'h0b, 8'hff);
    idle(1);
    check("p1 od oe", o_pin_oe[15:8], 8'ha4);
    check("p1 od high", o_pin_oe[15:8] & o_pin_out[15:8], 8'h00);
    // Memory bus on ports 0 and 1
    wr(7'h0b, 8'h00);
    wr(7'h0a, 8'hff);
    wr(7'h09, 8'hff);
    wr(7'h02, 8'hff);
    wr(7'h01, 8'hff);
    i_mem_en <= 1'b1;
    i_mem_high_addr <= 8'hc3;
    i_mem_addr_data_out <= 8'h96;
    i_mem_addr_data_oe <= 1'b1;
    idle(4);
    check("mem out", o_pin_out[15:0], 16'hc396);
    check("mem oe", o_pin_oe[15:0], 16'hffff);
    check("mem in", o_mem_addr_data_in, 8'h96);
    i_mem_addr_data_oe <= 1'b0;
    ext_en <= 80'hff;
    ext_val <= 80'h3c;
    idle(4);
    check("mem oe off", o_pin_oe[7:0], 8'h00);
    check("mem read", o_mem_addr_data_in, 8'h3c);
    // Alternate outputs on ports 4, 5, 9, peripherals on
    wr(7'h22, 8'hdc);
    wr(7'h21, 8'hdc);
    wr(7'h2a, 8'hf0);
    wr(7'h29, 8'hf0);
    wr(7'h4a, 8'h10);
    wr(7'h49, 8'h10);
    en <= 7'h7f;
    ext_en <= 80'h20000000d27000000000;
    ext_val <= '0;
    for (int k = 0; k < 2; k++) begin
      pf <= k ? 12'he4b : 12'h1b4;
      wr(7'h2d, k ? 8'ha0 : 8'h00);
      idle(5);
      check("af out", {o_pin_out[76], o_pin_out[47:44], o_pin_out[39:38], o_pin_out[36:34]},
        k ? 10'h253 : 10'h0ac);
      check("af oe", {o_pin_oe[76], o_pin_oe[47:44], o_pin_oe[39:38], o_pin_oe[36:34]}, 10'h3ff);
      check("af in blocked", periph, 8'h75);
    end
    // Back to bidirectional, pin 9.5 as schmitt input
    for (int k = 0; k < 8; k++) wr({k[1:0] == 2'h0 ? 4'h4 : k[1:0] == 2'h1 ? 4'h5 : 4'h9, k[2] ? 3'h1 : 3'h2}, 8'h00);
    wr(7'h4b, 8'h20);
    wr(7'h49, 8'h20);
    for (int k = 0; k < 2; k++) begin
      ext_val <= k ? 80'h20000000405000000000 : 80'h00000000922000000000;
      idle(5);
      check("af in", periph, k ? 8'ha5 : 8'h5a);
    end
    en <= 7'h00;
    idle(4);
    check("af in idle", periph, 8'hff);
    // Converter pin 7.0 needs all three bits
    wr(7'h3b, 8'h01);
    wr(7'h3a, 8'h01);
    idle(1);
    check("analog partial", o_analog_input_sel, 8'h00);
    wr(7'h39, 8'h01);
    idle(1);
    check("analog sel", o_analog_input_sel, 8'h01);
    // Threshold counts on port 2, not schmitt port 4
    wr(7'h13, 8'h01);
    wr(7'h23, 8'hff);
    idle(1);
    check("cmos", {o_pin_cmos[39:32], o_pin_cmos[23:16]}, 16'h0001);
    // Missing port slot, written then read at two selects
    wr(7'h19, 8'h77);
    rd(7'h19, 8'h00);
    rd(7'h1e, 8'h00);
    idle(1);
    close_out();
  end
endmodule
